// file: src/mhs_defines.svh
// Offsets, field codes and timing counts of the multi-plane select glue
`ifndef MHS_DEFINES_SVH
`define MHS_DEFINES_SVH

`define MHS_REG_FIFO 2'b11
`define MHS_BCAST_IDX 4
`define MHS_NUM_MGR 4
`define MHS_NIB_W 4
`define MHS_PTR_W 4
`define MHS_MEM_DEPTH 16
`define MHS_CLK_NS 20
`define MHS_READ_HOLD_NS 60
`define MHS_READ_HOLD_CYC (`MHS_READ_HOLD_NS / `MHS_CLK_NS)
`define MHS_TOP_NIB 16'hf000

`endif

// file: src/mhs_glue.sv
// Host select, transceiver steering and plane store for four pixel-plane managers
// Function
// RULE_01: Per-manager selects are qualified by the address latch strobe.
// RULE_02: Broadcast select with strobe asserts all four manager selects together.
// RULE_03: Broadcast uses the fifth 128-byte region; managers answer only their block.
// RULE_04: Host reaches one manager through that manager's own address block.
// RULE_05: Address bits two and one are latched as the register-select pair.
// RULE_06: Pixel-wide transceivers enable only on broadcast with address line three high.
// RULE_07: Pixel-wide read concatenates one nibble per manager into a 16-bit word.
// RULE_08: Pixel-wide write splits the 16-bit word, one nibble to each manager.
// RULE_09: Single-manager access, line three low, enables only that manager's transceivers.
// RULE_10: Broadcast with line three low enables regular transceivers, pixel path off.
// RULE_11: Each manager keeps four plane activity bits set by the activity command.
// RULE_12: Active planes work normally; inactive planes are never written.
// RULE_13: Driver enable needs select, FIFO register select and some active plane. Code enables on select alone when the FIFO register is not selected.
// RULE_14: Block writes store processor data only into active planes.
// RULE_15: Host keeps exactly one active plane in one manager for by-plane reads.
// RULE_16: Pixel-wide reads return ones in every inactive plane position.
// RULE_17: Read transceiver enable also needs the manager's driver enable.
// RULE_18: The read end state switches transceivers off to keep read hold.
// RULE_19: After each pixel-wide read every manager shifts its word left four bits. Code shifts only when the FIFO register is selected.
// RULE_20: Bus tracker steps one, two, three, wait and read end on reads only.
`include "mhs_defines.svh"

module mhs_glue
	import mhs_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [4:0] pcs_n_i,
	input wire logic address_latch_strobe_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic processor_data_enable_n_i,
	input wire logic [2:0] addr_i,
	input wire logic [15:0] data_i,
	input wire logic act_cmd_i,
	input wire logic [1:0] act_mgr_i,
	input wire logic [3:0] act_bits_i,
	output logic [3:0] cs_n_o,
	output logic [1:0] reg_sel_o,
	output logic [3:0] external_driver_enable_n_o,
	output logic [3:0] reg_oe_n_o,
	output logic pix_oe_n_o,
	output logic [15:0] data_o,
	output logic read_end_state_o,
	output logic [15:0] plane_active_bits_o
);

	localparam int READ_HOLD_CYC = `MHS_READ_HOLD_CYC;

	mhs_state_s st_r;
	mhs_state_s st_nxt;
	logic [3:0] sel;
	logic [3:0] ede;
	logic [3:0] reg_en;
	logic pix_en;
	logic bcast;
	logic fifo;
	logic rd_ok;
	logic wr_ok;
	logic [1:0] k;
	logic mem_we;
	logic [63:0] mem_wd;
	logic [63:0] mem_wm;
	logic [63:0] mem_rd;

	function automatic logic [15:0] nib_mask(input logic [3:0] a);
		nib_mask = {4{a}};
	endfunction

	function automatic logic [1:0] first_idx(input logic [3:0] s);
		first_idx = 2'h0;
		for (int i = 3; i >= 0; i--)
		begin
			if (s[i])
			begin
				first_idx = 2'(i);
			end
		end
	endfunction

	mhs_plane_mem u_mem
	(
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.addr_i(st_r.ptr),
		.we_i(mem_we),
		.wdata_i(mem_wd),
		.wmask_i(mem_wm),
		.rdata_o(mem_rd)
	);

	always_comb
	begin
		st_nxt = st_r;
		sel = 4'h0;
		ede = 4'h0;
		reg_en = 4'h0;
		pix_en = 1'b0;
		mem_we = 1'b0;
		mem_wd = 64'h0;
		mem_wm = 64'h0;
		// Bus pin inputs pass two flops before any decode; the activity command inputs are used directly
		st_nxt.pcs_m = ~pcs_n_i;
		st_nxt.pcs_s = st_r.pcs_m;
		st_nxt.ale_m = address_latch_strobe_i;
		st_nxt.ale_s = st_r.ale_m;
		st_nxt.rd_m = ~rd_n_i;
		st_nxt.rd_s = st_r.rd_m;
		st_nxt.wr_m = ~wr_n_i;
		st_nxt.wr_s = st_r.wr_m;
		st_nxt.den_m = ~processor_data_enable_n_i;
		st_nxt.den_s = st_r.den_m;
		st_nxt.adr_m = addr_i;
		st_nxt.adr_s = st_r.adr_m;
		st_nxt.dat_m = data_i;
		st_nxt.dat_s = st_r.dat_m;
		st_nxt.t1 = st_r.ale_s; // RULE_20
		st_nxt.t2 = st_r.t1; // RULE_20
		st_nxt.t3 = st_r.t2; // RULE_20
		st_nxt.tw = st_r.t3 & st_r.rd_s; // RULE_20
		st_nxt.t4 = st_r.tw; // RULE_20
		// Held off from read end until the read strobe drops, so no re-enable in the hold
		if (st_r.t4)
		begin
			st_nxt.rend = 1'b1; // RULE_18
		end
		else if (!st_r.rd_s)
		begin
			st_nxt.rend = 1'b0;
		end
		if (st_r.ale_s)
		begin
			st_nxt.rsel = st_r.adr_s[1:0]; // RULE_05
			st_nxt.a3 = st_r.adr_s[2];
		end
		if (act_cmd_i)
		begin
			st_nxt.act[{act_mgr_i, 2'b00} +: 4] = act_bits_i; // RULE_11
		end
		// Selects wait for the strobe to drop so the latched address is settled
		bcast = st_r.pcs_s[`MHS_BCAST_IDX] & ~st_r.ale_s; // RULE_03
		for (int i = 0; i < `MHS_NUM_MGR; i++)
		begin
			sel[i] = (st_r.pcs_s[i] | st_r.pcs_s[`MHS_BCAST_IDX]) & ~st_r.ale_s; // RULE_01 RULE_02
		end
		fifo = st_r.rsel == `MHS_REG_FIFO;
		for (int i = 0; i < `MHS_NUM_MGR; i++)
		begin
			ede[i] = sel[i] & (~fifo | (|st_r.act[4*i +: 4])); // RULE_13
		end
		if (sel == 4'h0)
		begin
			st_nxt.acc = ACC_IDLE;
		end
		else if (bcast & st_r.a3)
		begin
			st_nxt.acc = ACC_PIXEL;
		end
		else if (bcast)
		begin
			st_nxt.acc = ACC_BCAST;
		end
		else
		begin
			st_nxt.acc = ACC_SINGLE;
		end
		rd_ok = st_r.rd_s & st_r.den_s & ~st_r.rend & ~st_r.t4; // RULE_18
		wr_ok = st_r.wr_s & st_r.den_s;
		case (st_nxt.acc)
			ACC_PIXEL:
			begin
				pix_en = wr_ok | (rd_ok & (|ede)); // RULE_06 RULE_17
			end
			ACC_BCAST, ACC_SINGLE:
			begin
				for (int i = 0; i < `MHS_NUM_MGR; i++)
				begin
					reg_en[i] = sel[i] & (wr_ok | (rd_ok & ede[i])); // RULE_09 RULE_10 RULE_17
				end
			end
			default:
			begin
				reg_en = 4'h0;
			end
		endcase
		st_nxt.cs_n = ~sel;
		st_nxt.ede_n = ~ede;
		st_nxt.reg_oe_n = ~reg_en;
		st_nxt.pix_oe_n = ~pix_en;
		k = first_idx(sel);
		if (st_nxt.acc == ACC_PIXEL)
		begin
			for (int i = 0; i < `MHS_NUM_MGR; i++)
			begin
				st_nxt.dout[12-4*i +: 4] = st_r.sh[16*i+12 +: 4] | ~st_r.act[4*i +: 4]; // RULE_07 RULE_16
			end
		end
		else
		begin
			st_nxt.dout = mem_rd[{k, 4'h0} +: 16] | ~nib_mask(st_r.act[{k, 2'b00} +: 4]);
		end
		// Word reload lags a pointer change by two edges through the registered store
		st_nxt.ld = {st_r.ld[0], 1'b0};
		if (st_r.ld[1])
		begin
			st_nxt.sh = mem_rd;
		end
		if (st_r.t3 & st_r.wr_s & fifo & (|sel))
		begin
			mem_we = 1'b1;
			for (int i = 0; i < `MHS_NUM_MGR; i++)
			begin
				if (sel[i] && st_nxt.acc == ACC_PIXEL)
				begin
					mem_wd[16*i +: 16] = {4{st_r.dat_s[12-4*i +: 4]}}; // RULE_08
					mem_wm[16*i +: 16] = nib_mask(st_r.act[4*i +: 4])
						& (`MHS_TOP_NIB >> {st_r.pcnt, 2'b00}); // RULE_12 RULE_14
				end
				else if (sel[i])
				begin
					mem_wd[16*i +: 16] = st_r.dat_s;
					mem_wm[16*i +: 16] = nib_mask(st_r.act[4*i +: 4]); // RULE_12 RULE_14
				end
			end
		end
		if ((mem_we || (st_r.t4 && fifo && (|sel))) && st_nxt.acc == ACC_PIXEL)
		begin
			st_nxt.pcnt = st_r.pcnt + 2'h1;
			// Reload only with a new word, or it would undo the nibble shift
			if (st_r.pcnt == 2'h3)
			begin
				st_nxt.ptr = st_r.ptr + 4'h1;
				st_nxt.ld = 2'b01;
			end
		end
		else if (mem_we || (st_r.t4 && fifo && (|sel)))
		begin
			st_nxt.ptr = st_r.ptr + 4'h1;
			st_nxt.ld = 2'b01;
		end
		if (st_r.t4 && fifo && st_nxt.acc == ACC_PIXEL)
		begin
			for (int i = 0; i < `MHS_NUM_MGR; i++)
			begin
				st_nxt.sh[16*i +: 16] = {st_r.sh[16*i +: 12], 4'h0}; // RULE_19
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_r <= '0;
			st_r.ld <= 2'b01;
			st_r.cs_n <= 4'hf;
			st_r.ede_n <= 4'hf;
			st_r.reg_oe_n <= 4'hf;
			st_r.pix_oe_n <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign cs_n_o = st_r.cs_n;
	assign reg_sel_o = st_r.rsel;
	assign external_driver_enable_n_o = st_r.ede_n;
	assign reg_oe_n_o = st_r.reg_oe_n;
	assign pix_oe_n_o = st_r.pix_oe_n;
	assign data_o = st_r.dout;
	assign read_end_state_o = st_r.t4;
	assign plane_active_bits_o = st_r.act;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_addr_phase;
		st_r.ale_s ##1 st_r.t1 ##1 st_r.t2 ##1 st_r.t3;
	endsequence

	sequence s_read_tail;
		st_r.t3 && st_r.rd_s ##1 st_r.tw ##1 st_r.t4;
	endsequence

	AST_CS_QUAL: assert property (cs_n_o != 4'hf |-> $past(!st_r.ale_s)) // RULE_01
		else $error("select asserted while latch strobe active");

	AST_BCAST_ALL: assert property (st_r.pcs_s[4] && !st_r.ale_s |=> cs_n_o == 4'h0) // RULE_02
		else $error("broadcast did not select all managers");

	AST_PIX_BCAST: assert property (!pix_oe_n_o |-> $past(st_r.pcs_s[4] && st_r.a3)) // RULE_06
		else $error("pixel transceivers on outside broadcast with line three high");

	AST_EDE_ACT: assert property (!external_driver_enable_n_o[0] && $past(st_r.rsel) == 2'b11
		|-> $past(|st_r.act[3:0])) // RULE_13
		else $error("driver enable with no active plane");

	AST_RD_EDE: assert property (!reg_oe_n_o[0] && $past(st_r.rd_s)
		|-> !external_driver_enable_n_o[0]) // RULE_17
		else $error("read transceiver on without driver enable");

	AST_T4_OFF: assert property (s_read_tail |=> ##[0:READ_HOLD_CYC]
		(reg_oe_n_o == 4'hf && pix_oe_n_o)) // RULE_18
		else $error("transceivers still on after read end");

	AST_TRACK: assert property (s_addr_phase ##0 !st_r.rd_s |=> !st_r.tw ##1 !st_r.t4) // RULE_20
		else $error("wait or read end on a write cycle");

	AST_SHIFT: assert property (st_r.t4 && st_r.rsel == 2'b11 && st_nxt.acc == ACC_PIXEL
		&& !st_r.ld[1] |=> st_r.sh[15:0] == {$past(st_r.sh[11:0]), 4'h0}) // RULE_19
		else $error("manager word not shifted after pixel read");

	AST_ONES: assert property (st_r.acc == ACC_PIXEL
		|-> (data_o[11:8] | $past(st_r.act[7:4])) == 4'hf) // RULE_16
		else $error("inactive plane did not read as one");

endmodule

// file: src/mhs_pkg.sv
// Types shared by the multi-plane select glue
package mhs_pkg;

	typedef enum logic [1:0]
	{
		ACC_IDLE = 2'b00,
		ACC_SINGLE = 2'b01,
		ACC_BCAST = 2'b10,
		ACC_PIXEL = 2'b11
	} mhs_acc_e;

	typedef struct packed
	{
		logic [4:0] pcs_m;
		logic [4:0] pcs_s;
		logic ale_m;
		logic ale_s;
		logic rd_m;
		logic rd_s;
		logic wr_m;
		logic wr_s;
		logic den_m;
		logic den_s;
		logic [2:0] adr_m;
		logic [2:0] adr_s;
		logic [15:0] dat_m;
		logic [15:0] dat_s;
		logic t1;
		logic t2;
		logic t3;
		logic tw;
		logic t4;
		logic rend;
		logic [1:0] rsel;
		logic a3;
		mhs_acc_e acc;
		logic [15:0] act;
		logic [3:0] ptr;
		logic [1:0] pcnt;
		logic [1:0] ld;
		logic [63:0] sh;
		logic [3:0] cs_n;
		logic [3:0] ede_n;
		logic [3:0] reg_oe_n;
		logic pix_oe_n;
		logic [15:0] dout;
	} mhs_state_s;

endpackage

// file: src/mhs_plane_mem.sv
// Display word store for four managers, bit-masked writes, registered read
module mhs_plane_mem
	import mhs_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] addr_i,
	input wire logic we_i,
	input wire logic [63:0] wdata_i,
	input wire logic [63:0] wmask_i,
	output logic [63:0] rdata_o
);

	logic [63:0] mem [0:15];

	// Bit mask lets an inactive plane keep its contents on a write
	always_ff @(posedge ref_clk_i)
	begin
		if (we_i)
		begin
			for (int b = 0; b < 64; b++)
			begin
				if (wmask_i[b])
				begin
					mem[addr_i][b] <= wdata_i[b];
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rdata_o <= 64'h0;
		end
		else
		begin
			rdata_o <= mem[addr_i];
		end
	end

endmodule

// file: verification/mhs_host.sv
// Host processor bus model driving strobe, selects and read or write strobes
module mhs_host (
	input wire logic clk_i,
	output logic [4:0] pcs_n_o,
	output logic ale_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic den_n_o,
	output logic [2:0] addr_o,
	output logic [15:0] data_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		pcs_n_o = 5'h1f;
		ale_o = 1'b0;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		den_n_o = 1'b1;
		addr_o = 3'h0;
		data_o = 16'h0;
	end

	// Select only after the strobe falls, so the address is already latched
	task automatic start(input logic [4:0] sel_n, input logic [2:0] a, input logic wr,
		input logic [15:0] d);
		@(negedge clk_i);
		addr_o = a;
		ale_o = 1'b1;
		if (wr)
			data_o = d;
		@(negedge clk_i);
		ale_o = 1'b0;
		pcs_n_o = sel_n;
		@(negedge clk_i);
		rd_n_o = wr;
		wr_n_o = !wr;
		den_n_o = 1'b0;
		repeat (8) @(negedge clk_i);
	endtask

	task automatic finish();
		@(negedge clk_i);
		pcs_n_o = 5'h1f;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		den_n_o = 1'b1;
		// A released bus must not keep showing the last word
		data_o = ~data_o;
		repeat (4) @(negedge clk_i);
	endtask
endmodule

// file: verification/multi_plane_host_select_glue_bench.sv
// Self-checking bench for the multi-plane select glue
module multi_plane_host_select_glue_bench;
	import mhs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic act_cmd_i = 1'b0;
	logic [1:0] act_mgr_i = 2'h0;
	logic [3:0] act_bits_i = 4'h0;
	logic [4:0] pcs_n;
	logic ale;
	logic rd_n;
	logic wr_n;
	logic den_n;
	logic [2:0] addr;
	logic [15:0] wdata;
	logic [3:0] cs_n_o;
	logic [3:0] ede_n_o;
	logic [3:0] reg_oe_n_o;
	logic [1:0] reg_sel_o;
	logic pix_oe_n_o;
	logic read_end_state_o;
	logic [15:0] data_o;
	logic [15:0] plane_active_bits_o;
	logic [15:0] exp_q[$];
	logic [15:0] pix[4];
	int error_cnt = 0;
	int total_checks = 0;

	always #10 ref_clk_i = ~ref_clk_i;

	mhs_host HOST (.clk_i(ref_clk_i), .pcs_n_o(pcs_n), .ale_o(ale), .rd_n_o(rd_n),
		.wr_n_o(wr_n), .den_n_o(den_n), .addr_o(addr), .data_o(wdata));

	mhs_glue DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pcs_n_i(pcs_n),
		.address_latch_strobe_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.processor_data_enable_n_i(den_n), .addr_i(addr), .data_i(wdata),
		.act_cmd_i(act_cmd_i), .act_mgr_i(act_mgr_i), .act_bits_i(act_bits_i),
		.cs_n_o(cs_n_o), .reg_sel_o(reg_sel_o), .external_driver_enable_n_o(ede_n_o),
		.reg_oe_n_o(reg_oe_n_o), .pix_oe_n_o(pix_oe_n_o), .data_o(data_o),
		.read_end_state_o(read_end_state_o), .plane_active_bits_o(plane_active_bits_o));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic do_reset();
		@(negedge ref_clk_i);
		rst_n_i = 1'b0;
		repeat (2) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
	endtask

	task automatic set_act(input logic [1:0] m, input logic [3:0] b);
		@(negedge ref_clk_i);
		act_cmd_i = 1'b1;
		act_mgr_i = m;
		act_bits_i = b;
		@(negedge ref_clk_i);
		act_cmd_i = 1'b0;
	endtask

	task automatic all_act();
		for (int m = 0; m < 4; m++)
			set_act(m[1:0], 4'hf);
	endtask

	task automatic pix_read(input logic [15:0] e);
		exp_q.push_back(e);
		HOST.start(5'h0f, 3'b111, 1'b0, 16'h0);
		HOST.finish();
	endtask

	// Each read end pulse retires the oldest expected read word; writes must not pulse
	// Read data stands with the pulse; one edge later the pixel word has shifted on
	always @(negedge ref_clk_i)
	begin
		if (read_end_state_o === 1'b1)
		begin
			if (exp_q.size() == 0)
			begin
				error_cnt++;
				$display("Error %0t: read end without a read", $time);
			end
			else
				chk(data_o, exp_q.pop_front());
		end
	end

	initial
	begin
		repeat (20000) @(posedge ref_clk_i);
		error_cnt++;
		$display("Error %0t: run hung", $time);
		complete_run();
	end

	initial
	begin
		void'($urandom(26923));
		do_reset();
		chk({cs_n_o, ede_n_o, reg_oe_n_o, pix_oe_n_o, read_end_state_o, 2'h3}, 16'hfffb);
		all_act();
		chk(plane_active_bits_o, 16'hffff);
		for (int m = 0; m < 4; m++)
		begin
			HOST.start(~(5'h1 << m), {1'b0, m[1:0]}, 1'b1, 16'h0);
			chk({cs_n_o, reg_oe_n_o, reg_sel_o, 5'h0, pix_oe_n_o},
				{~(4'h1 << m), ~(4'h1 << m), m[1:0], 5'h0, 1'b1});
			HOST.finish();
		end
		HOST.start(5'h1e, 3'b100, 1'b1, 16'h0);
		chk({cs_n_o, reg_oe_n_o, 7'h0, pix_oe_n_o}, 16'hee01);
		HOST.finish();
		HOST.start(5'h0f, 3'b000, 1'b1, 16'h0);
		chk({cs_n_o, reg_oe_n_o, 7'h0, pix_oe_n_o}, 16'h0001);
		HOST.finish();
		// Fresh pointer for the pixel store, then four packed pixels
		do_reset();
		all_act();
		for (int i = 0; i < 4; i++)
		begin
			pix[i] = 16'($urandom);
			HOST.start(5'h0f, 3'b111, 1'b1, pix[i]);
			chk({15'h0, pix_oe_n_o}, 16'h0);
			HOST.finish();
		end
		do_reset();
		all_act();
		for (int i = 0; i < 4; i++)
			pix_read(pix[i]);
		do_reset();
		all_act();
		set_act(2'h1, 4'h5);
		pix_read(pix[0] | 16'h0a00);
		// By-plane read: one active plane in one manager only
		for (int m = 0; m < 4; m++)
			set_act(m[1:0], (m == 0) ? 4'h1 : 4'h0);
		exp_q.push_back({pix[0][15:12], pix[1][15:12], pix[2][15:12], pix[3][15:12]} | 16'heeee);
		HOST.start(5'h0f, 3'b011, 1'b0, 16'h0);
		chk({8'h0, ede_n_o, reg_oe_n_o}, 16'h00ef);
		HOST.finish();
		for (int i = 0; i < 50 && exp_q.size() > 0; i++)
			@(negedge ref_clk_i);
		if (exp_q.size() > 0)
		begin
			error_cnt++;
			$display("Error %0t: read end missing", $time);
		end
		complete_run();
	end
endmodule
